/* shared/port_tag_params.svh */
// Register offsets, field positions, reset values and framing constants of the port tag block
`ifndef PORT_TAG_PARAMS_SVH
`define PORT_TAG_PARAMS_SVH

// Word indices on the register bus (byte address = index * 4)
`define IDX_PORT1     6'h00
`define IDX_PORT5     6'h04
`define IDX_GLOBAL    6'h05
`define IDX_DSCP0     6'h06
`define IDX_DSCP3     6'h09
`define IDX_STATUS    6'h0a

// Per-port control word fields
`define PC_STRIP      1
`define PC_INSERT     2
`define PC_CEIL       7
`define PC_PCP_LSB    8
`define PC_TX_EN      12
`define PC_RX_EN      13
`define PC_LEARN_DIS  14
`define PC_VID_LSB    16

// Global control word fields
`define GL_TAIL_EN    1
`define GL_FLUSH_STA  4
`define GL_FLUSH_DYN  5

// Reset values
`define PC_RESET      32'h0001_3000
`define GL_RESET      32'h0000_0000
`define GL_FLUSH_MASK 32'h0000_0030

// Framing constants
`define TPID_HI       8'h81
`define TPID_LO       8'h00
`define CRC_INIT      32'hffff_ffff
`define CRC_POLY      32'hedb8_8320
`define TAG_POS       5'h0c
`define TAG_END       5'h10
`define HOST_PORT     3'h5

`endif

/* shared/port_tag_pkg.sv */
// Types shared by the port tag block
package port_tag_pkg;
  // Egress editor phases
  typedef enum logic [1:0] {
    ED_DATA   = 2'b00,
    ED_INSERT = 2'b01,
    ED_TAIL   = 2'b10,
    ED_FCS    = 2'b11
  } edit_state_e;

  // One bit per switch port, bit 0 = port 1, bit 4 = host port
  typedef logic [4:0] port_mask_t;
endpackage

/* core/crc32_calc.sv */
// One byte step of the reflected Ethernet CRC-32
`include "port_tag_params.svh"

module crc32_calc (
  // Running remainder and next byte
  input  wire logic [31:0] crc_i,
  input  wire logic [7:0]  data_i,
  // Remainder after the byte
  output logic      [31:0] crc_o
);

  // Bit-serial fold, least significant bit first as on the wire
  always_comb begin
    crc_o = crc_i;
    for (int i = 0; i < 8; i++) begin
      if (crc_o[0] ^ data_i[i]) begin
        crc_o = (crc_o >> 1) ^ `CRC_POLY;
      end else begin
        crc_o = crc_o >> 1;
      end
    end
  end

endmodule // crc32_calc

/* core/tail_tag_decode.sv */
// Decoder for the tail tag byte a host appends to frames it sends
module tail_tag_decode (
  // Tag byte
  input  wire logic [7:0] tag_i,
  // Decoded fields
  output logic            lookup_o,
  output logic            directed_o,
  output logic            reserved_o,
  output logic      [3:0] dest_o,
  output logic      [1:0] queue_o,
  output logic            queue_valid_o
);

  // Bit 7 hands the frame to address lookup, else bits [3:0] steer it
  always_comb begin
    lookup_o      = tag_i[7];
    directed_o    = 1'b0;
    reserved_o    = 1'b0;
    dest_o        = 4'h0;
    queue_o       = tag_i[5:4];
    queue_valid_o = 1'b0;
    if (!tag_i[7]) begin
      unique case (tag_i[3:0])
        4'h1, 4'h2, 4'h4, 4'h8, 4'hf: begin
          dest_o     = tag_i[3:0];
          directed_o = 1'b1;
        end
        // All-zero and non-listed masks are refused rather than guessed
        default: begin
          reserved_o = 1'b1;
        end
      endcase
      queue_valid_o = directed_o & ~tag_i[6];
    end
  end

endmodule // tail_tag_decode

/* core/switch_port_state_tail_tag.sv */
// Per-port frame handling: tag edit, priority, spanning tree gating, tail tag
`include "port_tag_params.svh"

module switch_port_state_tail_tag (
  // Clock and reset
  input  wire logic                     SYS_CLK_I,
  input  wire logic                     RESET_N_I,
  // Avalon-MM register slave
  input  wire logic [7:0]               AVS_ADDRESS_I,
  input  wire logic                     AVS_READ_I,
  input  wire logic                     AVS_WRITE_I,
  input  wire logic [31:0]              AVS_WRITEDATA_I,
  input  wire logic [3:0]               AVS_BYTEENABLE_I,
  output logic      [31:0]              AVS_READDATA_O,
  output logic                          AVS_WAITREQUEST_O,
  // Ingress classification request
  input  wire logic                     IN_VALID_I,
  input  wire logic [2:0]               IN_PORT_I,
  input  wire logic                     IN_TAGGED_I,
  input  wire logic [2:0]               IN_PCP_I,
  input  wire logic                     IN_IS_IP_I,
  input  wire logic [7:0]               IN_TOS_I,
  input  wire port_tag_pkg::port_mask_t IN_LOOKUP_MASK_I,
  input  wire logic                     IN_OVERRIDE_HIT_I,
  input  wire logic [7:0]               IN_TAIL_TAG_I,
  // Ingress classification answer
  output logic                          CL_VALID_O,
  output logic      [2:0]               CL_PCP_O,
  output logic      [1:0]               CL_DSCP_PRIO_O,
  output port_tag_pkg::port_mask_t      CL_FWD_MASK_O,
  output logic      [1:0]               CL_QUEUE_O,
  output logic                          CL_QUEUE_VALID_O,
  output logic                          CL_LEARN_O,
  // Address table flush requests
  output logic                          FLUSH_DYN_O,
  output logic                          FLUSH_STA_O,
  output logic      [3:0]               FLUSH_PORTS_O,
  // Egress byte stream in, frame without check sequence
  input  wire logic                     EG_VALID_I,
  input  wire logic [7:0]               EG_DATA_I,
  input  wire logic                     EG_LAST_I,
  input  wire logic [2:0]               EG_SRC_PORT_I,
  input  wire logic [2:0]               EG_DST_PORT_I,
  input  wire logic                     EG_TAGGED_I,
  output logic                          EG_READY_O,
  // Egress byte stream out, with check sequence
  output logic                          TX_VALID_O,
  output logic      [7:0]               TX_DATA_O,
  output logic                          TX_LAST_O,
  input  wire logic                     TX_READY_I
);
  import port_tag_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [4:0][31:0] pc;
    logic [31:0]      gl;
    logic [127:0]     dscp;
    logic             ack;
    logic [31:0]      rdata;
    logic             flush_dyn;
    logic             flush_sta;
    logic [3:0]       flush_ports;
    logic             cl_valid;
    logic [2:0]       cl_pcp;
    logic [1:0]       cl_prio;
    port_mask_t       cl_mask;
    logic [1:0]       cl_queue;
    logic             cl_qv;
    logic             cl_learn;
    logic [7:0]       last_tail;
    edit_state_e      st;
    logic [4:0]       cnt;
    logic [1:0]       idx;
    logic             ins_done;
    logic [31:0]      crc;
    logic             tx_valid;
    logic [7:0]       tx_data;
    logic             tx_last;
    logic [15:0]      frames;
  } main_state_s;

  main_state_s s_reg;
  main_state_s s_next;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // One-hot mask bit of a port number, zero for out-of-range numbers
  function automatic port_mask_t port_bit(input logic [2:0] p);
    unique case (p)
      3'h1: port_bit = 5'h01;
      3'h2: port_bit = 5'h02;
      3'h3: port_bit = 5'h04;
      3'h4: port_bit = 5'h08;
      3'h5: port_bit = 5'h10;
      default: port_bit = 5'h00;
    endcase
  endfunction

  // Control word slot of a port; stray numbers fall on port 1
  function automatic logic [2:0] pidx(input logic [2:0] p);
    pidx = (p >= 3'h1 && p <= 3'h5) ? p - 3'h1 : 3'h0;
  endfunction

  // Byte-enable merge of a bus write
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    for (int b = 0; b < 4; b++) begin
      be_merge[8*b +: 8] = be[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
    end
  endfunction

  // ****************************************************************
  // Submodules
  // ****************************************************************
  logic        emit;
  logic        emit_last;
  logic        emit_crc;
  logic [7:0]  emit_byte;
  logic [31:0] crc_n;
  logic        tt_lookup;
  logic        tt_directed;
  logic        tt_reserved;
  logic [3:0]  tt_dest;
  logic [1:0]  tt_queue;
  logic        tt_qv;

  crc32_calc u_crc (
    .crc_i  (s_reg.crc),
    .data_i (emit_byte),
    .crc_o  (crc_n)
  );

  tail_tag_decode u_tail (
    .tag_i         (IN_TAIL_TAG_I),
    .lookup_o      (tt_lookup),
    .directed_o    (tt_directed),
    .reserved_o    (tt_reserved),
    .dest_o        (tt_dest),
    .queue_o       (tt_queue),
    .queue_valid_o (tt_qv)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic        req;
  logic        out_free;
  logic        tail_en;
  logic        dropping;
  logic        do_ins;
  logic [31:0] src_pc;
  logic [31:0] dst_pc;
  logic [31:0] in_pc;
  logic [15:0] tci;
  logic [5:0]  ridx;
  logic [2:0]  dflt_pcp;
  logic [5:0]  cp;
  port_mask_t  tx_ok;
  port_mask_t  in_bit;
  port_mask_t  mask;

  assign req               = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = req & ~s_reg.ack;
  assign out_free          = ~s_reg.tx_valid | TX_READY_I;
  assign tail_en           = s_reg.gl[`GL_TAIL_EN];
  assign src_pc            = s_reg.pc[pidx(EG_SRC_PORT_I)];
  assign dst_pc            = s_reg.pc[pidx(EG_DST_PORT_I)];
  assign in_pc             = s_reg.pc[pidx(IN_PORT_I)];
  assign ridx              = AVS_ADDRESS_I[7:2];
  assign dropping          = dst_pc[`PC_STRIP] & EG_TAGGED_I
                             & s_reg.cnt >= `TAG_POS & s_reg.cnt < `TAG_END;
  assign do_ins            = dst_pc[`PC_INSERT] & ~EG_TAGGED_I & ~s_reg.ins_done;
  assign tci               = {src_pc[`PC_PCP_LSB +: 3], 1'b0, src_pc[`PC_VID_LSB +: 12]};
  assign EG_READY_O        = s_reg.st == ED_DATA & (out_free | dropping)
                             & ~(s_reg.cnt == `TAG_POS & do_ins);

  // Ports 1-4 gate transmit by their state; the host port never closes
  always_comb begin
    tx_ok = 5'h10;
    for (int p = 0; p < 4; p++) begin
      tx_ok[p] = s_reg.pc[p][`PC_TX_EN];
    end
  end

  always_comb begin
    s_next              = s_reg;
    s_next.flush_dyn    = 1'b0;
    s_next.flush_sta    = 1'b0;
    s_next.cl_valid     = 1'b0;
    emit                = 1'b0;
    emit_last           = 1'b0;
    emit_crc            = 1'b1;
    emit_byte           = EG_DATA_I;
    dflt_pcp            = in_pc[`PC_PCP_LSB +: 3];
    cp                  = IN_TOS_I[7:2];
    in_bit              = port_bit(IN_PORT_I);
    mask                = 5'h00;

    // Register bus: answer on the second edge, write on that same edge
    s_next.ack = req & ~s_reg.ack;
    if (AVS_READ_I & ~s_reg.ack) begin
      s_next.rdata = 32'h0000_0000;
      if (ridx <= `IDX_PORT5) begin
        s_next.rdata = s_reg.pc[ridx[2:0]];
      end else if (ridx == `IDX_GLOBAL) begin
        s_next.rdata = s_reg.gl;
      end else if (ridx >= `IDX_DSCP0 && ridx <= `IDX_DSCP3) begin
        s_next.rdata = s_reg.dscp[32*(ridx - `IDX_DSCP0) +: 32];
      end else if (ridx == `IDX_STATUS) begin
        s_next.rdata = {8'h00, s_reg.frames, s_reg.last_tail};
      end
    end
    if (AVS_WRITE_I & s_reg.ack) begin
      if (ridx <= `IDX_PORT5) begin
        s_next.pc[ridx[2:0]] = be_merge(s_reg.pc[ridx[2:0]], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end else if (ridx == `IDX_GLOBAL) begin
        // Flush bits act once and never read back as set
        s_next.gl = be_merge(s_reg.gl, AVS_WRITEDATA_I, AVS_BYTEENABLE_I) & ~`GL_FLUSH_MASK;
        s_next.flush_dyn = AVS_BYTEENABLE_I[0] & AVS_WRITEDATA_I[`GL_FLUSH_DYN];
        s_next.flush_sta = AVS_BYTEENABLE_I[0] & AVS_WRITEDATA_I[`GL_FLUSH_STA];
        for (int p = 0; p < 4; p++) begin
          s_next.flush_ports[p] = s_reg.pc[p][`PC_LEARN_DIS];
        end
      end else if (ridx >= `IDX_DSCP0 && ridx <= `IDX_DSCP3) begin
        s_next.dscp[32*(ridx - `IDX_DSCP0) +: 32] =
          be_merge(s_reg.dscp[32*(ridx - `IDX_DSCP0) +: 32], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
    end

    // Ingress classification, one cycle after the request
    if (IN_VALID_I) begin
      s_next.cl_valid = 1'b1;
      s_next.cl_pcp   = (in_pc[`PC_CEIL] & IN_TAGGED_I & IN_PCP_I > dflt_pcp)
                        ? dflt_pcp : IN_PCP_I;
      s_next.cl_prio  = IN_IS_IP_I ? s_reg.dscp[{cp, 1'b0} +: 2] : 2'h0;
      s_next.cl_queue = 2'h0;
      s_next.cl_qv    = 1'b0;
      if (IN_PORT_I == `HOST_PORT) begin
        // Host frames: tail tag steers them when the mode is on
        s_next.cl_learn = 1'b1;
        if (tail_en) begin
          s_next.last_tail = IN_TAIL_TAG_I;
          if (tt_lookup) begin
            mask = IN_LOOKUP_MASK_I & tx_ok & 5'h0f;
          end else if (tt_directed) begin
            // Directed frames bypass port state: the host owns that choice
            mask            = {1'b0, tt_dest};
            s_next.cl_queue = tt_queue;
            s_next.cl_qv    = tt_qv;
          end else begin
            mask = 5'h00;
          end
        end else begin
          mask = IN_LOOKUP_MASK_I & tx_ok & 5'h0f;
        end
      end else begin
        // Ports 1-4: receive enable, learn disable and override select the path
        s_next.cl_learn = ~in_pc[`PC_LEARN_DIS];
        if (in_pc[`PC_RX_EN]) begin
          mask = IN_LOOKUP_MASK_I & tx_ok & ~in_bit;
        end else if (IN_OVERRIDE_HIT_I) begin
          mask = 5'h10;
        end else if (~in_pc[`PC_LEARN_DIS]) begin
          mask = IN_LOOKUP_MASK_I & 5'h10;
        end else begin
          mask = 5'h00;
        end
      end
      s_next.cl_mask = mask;
    end

    // Egress editor; output register drains, last flag with it, when the sink takes a byte
    if (s_reg.tx_valid & TX_READY_I) begin
      s_next.tx_valid = 1'b0;
      s_next.tx_last  = 1'b0;
    end
    unique case (s_reg.st)
      ED_DATA: begin
        if (EG_VALID_I & EG_READY_O) begin
          if (s_reg.cnt != `TAG_END) begin
            s_next.cnt = s_reg.cnt + 5'h01;
          end
          emit = ~dropping;
          if (EG_LAST_I) begin
            s_next.idx = 2'h0;
            s_next.st  = (EG_DST_PORT_I == `HOST_PORT & tail_en) ? ED_TAIL : ED_FCS;
          end
        end else if (s_reg.cnt == `TAG_POS & do_ins) begin
          s_next.idx = 2'h0;
          s_next.st  = ED_INSERT;
        end
      end
      ED_INSERT: begin
        if (out_free) begin
          emit = 1'b1;
          unique case (s_reg.idx)
            2'h0: emit_byte = `TPID_HI;
            2'h1: emit_byte = `TPID_LO;
            2'h2: emit_byte = tci[15:8];
            2'h3: emit_byte = tci[7:0];
          endcase
          s_next.idx = s_reg.idx + 2'h1;
          if (s_reg.idx == 2'h3) begin
            s_next.ins_done = 1'b1;
            s_next.st       = ED_DATA;
          end
        end
      end
      ED_TAIL: begin
        // Tail byte goes last in the data, covered by the check sequence
        if (out_free) begin
          emit       = 1'b1;
          emit_byte  = {6'h00, EG_SRC_PORT_I[1:0] - 2'h1};
          s_next.idx = 2'h0;
          s_next.st  = ED_FCS;
        end
      end
      ED_FCS: begin
        if (out_free) begin
          emit      = 1'b1;
          emit_crc  = 1'b0;
          emit_byte = ~s_reg.crc[8*s_reg.idx +: 8];
          emit_last = s_reg.idx == 2'h3;
          s_next.idx = s_reg.idx + 2'h1;
          if (s_reg.idx == 2'h3) begin
            s_next.st       = ED_DATA;
            s_next.cnt      = 5'h00;
            s_next.ins_done = 1'b0;
            s_next.crc      = `CRC_INIT;
            s_next.frames   = s_reg.frames + 16'h0001;
          end
        end
      end
    endcase
    if (emit) begin
      s_next.tx_valid = 1'b1;
      s_next.tx_data  = emit_byte;
      s_next.tx_last  = emit_last;
      if (emit_crc) begin
        s_next.crc = crc_n;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset loads constants only; control words open all ports
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s_reg     <= '0;
      s_reg.pc  <= {5{`PC_RESET}};
      s_reg.gl  <= `GL_RESET;
      s_reg.crc <= `CRC_INIT;
      s_reg.st  <= ED_DATA;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign AVS_READDATA_O   = s_reg.rdata;
  assign CL_VALID_O       = s_reg.cl_valid;
  assign CL_PCP_O         = s_reg.cl_pcp;
  assign CL_DSCP_PRIO_O   = s_reg.cl_prio;
  assign CL_FWD_MASK_O    = s_reg.cl_mask;
  assign CL_QUEUE_O       = s_reg.cl_queue;
  assign CL_QUEUE_VALID_O = s_reg.cl_qv;
  assign CL_LEARN_O       = s_reg.cl_learn;
  assign FLUSH_DYN_O      = s_reg.flush_dyn;
  assign FLUSH_STA_O      = s_reg.flush_sta;
  assign FLUSH_PORTS_O    = s_reg.flush_ports;
  assign TX_VALID_O       = s_reg.tx_valid;
  assign TX_DATA_O        = s_reg.tx_data;
  assign TX_LAST_O        = s_reg.tx_last;

endmodule // switch_port_state_tail_tag

/* verif/port_tag_checker.sv */
// Assertions on the ports of the port tag block
module port_tag_checker (
  // Clock and reset
  input wire logic       SYS_CLK_I,
  input wire logic       RESET_N_I,
  // Register bus handshake
  input wire logic       AVS_READ_I,
  input wire logic       AVS_WRITE_I,
  input wire logic       AVS_WAITREQUEST_O,
  // Classification handshake
  input wire logic       IN_VALID_I,
  input wire logic       CL_VALID_O,
  // Egress streams
  input wire logic       EG_VALID_I,
  input wire logic       EG_READY_O,
  input wire logic       EG_LAST_I,
  input wire logic       TX_VALID_O,
  input wire logic       TX_LAST_O,
  input wire logic       TX_READY_I,
  input wire logic [7:0] TX_DATA_O,
  // Flush pulses
  input wire logic       FLUSH_DYN_O,
  input wire logic       FLUSH_STA_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Register bus: every request sees exactly one wait state
  property p_wait_first;
    $rose(AVS_READ_I) || $rose(AVS_WRITE_I) |-> AVS_WAITREQUEST_O;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("request answered at once");
  property p_one_wait;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("register answer late");
  // Classification answer is a one-cycle pulse after each request
  property p_cl_answer;
    IN_VALID_I |=> CL_VALID_O;
  endproperty
  a_cl_answer: assert property (p_cl_answer) else $error("classification missing");
  property p_cl_pulse;
    !IN_VALID_I |=> !CL_VALID_O;
  endproperty
  a_cl_pulse: assert property (p_cl_pulse) else $error("classification without request");
  // Output byte must not move while the host stalls
  property p_tx_hold;
    TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O) && $stable(TX_LAST_O);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("output byte changed in stall");
  property p_last_valid;
    TX_LAST_O |-> TX_VALID_O;
  endproperty
  a_last_valid: assert property (p_last_valid) else $error("last without valid");
  // Four check bytes follow every frame before new input is taken
  property p_fcs_gap;
    EG_VALID_I && EG_READY_O && EG_LAST_I |=> !EG_READY_O [*4];
  endproperty
  a_fcs_gap: assert property (p_fcs_gap) else $error("input taken during check bytes");
  // Flush requests are single pulses
  property p_flush_pulse;
    FLUSH_DYN_O || FLUSH_STA_O |=> !FLUSH_DYN_O && !FLUSH_STA_O;
  endproperty
  a_flush_pulse: assert property (p_flush_pulse) else $error("flush held too long");
endmodule // port_tag_checker

/* verif/host_rx_model.sv */
// Host receive side model: takes output bytes, stalling three cycles in four when slow
module host_rx_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Pace select and ready
  input  wire logic slow_i,
  output logic      ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_reg;
  // Free phase counter; stalls test the output hold logic
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
  assign ready_o = !slow_i || (cnt_reg == 2'h3);
endmodule // host_rx_model

/* verif/tb_top.sv */
// Self-checking bench of the port tag block
`include "port_tag_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, iv = 0, itg = 0, iip = 0, ovr = 0;
  logic ev = 0, el = 0, etg = 0, slow = 0, wreq, cv, qv, lrn, fd, fs, ery, tv, tl, trdy;
  logic [7:0] adr = 0, itos = 0, itail = 0, ed = 0, td;
  logic [31:0] wd = 0, rdata, rng = 32'd89710;
  logic [2:0] ip = 0, ipcp = 0, es = 0, edst = 0, cpcp;
  logic [1:0] cds, cq;
  logic [3:0] fp;
  logic [27:0] ce;
  port_tag_pkg::port_mask_t ilk = 0, cm;
  logic [8:0] txq[$];
  logic [27:0] clq[$];
  logic [31:0] regq[$];
  int failures = 0, samples_checked = 0, cyc = 0;
  switch_port_state_tail_tag i_dut (
    .SYS_CLK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wreq), .IN_VALID_I(iv), .IN_PORT_I(ip), .IN_TAGGED_I(itg),
    .IN_PCP_I(ipcp), .IN_IS_IP_I(iip), .IN_TOS_I(itos), .IN_LOOKUP_MASK_I(ilk),
    .IN_OVERRIDE_HIT_I(ovr), .IN_TAIL_TAG_I(itail), .CL_VALID_O(cv), .CL_PCP_O(cpcp),
    .CL_DSCP_PRIO_O(cds), .CL_FWD_MASK_O(cm), .CL_QUEUE_O(cq), .CL_QUEUE_VALID_O(qv),
    .CL_LEARN_O(lrn), .FLUSH_DYN_O(fd), .FLUSH_STA_O(fs), .FLUSH_PORTS_O(fp),
    .EG_VALID_I(ev), .EG_DATA_I(ed), .EG_LAST_I(el), .EG_SRC_PORT_I(es), .EG_DST_PORT_I(edst),
    .EG_TAGGED_I(etg), .EG_READY_O(ery), .TX_VALID_O(tv), .TX_DATA_O(td), .TX_LAST_O(tl),
    .TX_READY_I(trdy));
  host_rx_model i_host (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .ready_o(trdy));
  // Clock
  initial forever #20 clk = ~clk;
  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [31:0] crc8(logic [31:0] c, logic [7:0] d);
    c ^= {24'h0, d};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
    return c;
  endfunction
  // Waits for the rising edge that completes the handshake; only the timeout ends a hang
  task automatic accept(logic avs);
    do @(posedge clk); while (!(avs ? wreq === 1'b0 : ery === 1'b1));
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    accept(1);
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic rdx(logic [7:0] a, logic [31:0] e);
    regq.push_back(e);
    bus(0, a, 32'h0);
  endtask
  // Expected fields: {mask, learn, pcp, dscp, queue, queue valid} under a care mask
  task automatic cls(logic [2:0] p, logic t, logic [2:0] pc, logic [7:0] tos, logic [4:0] lk,
                     logic o, logic [7:0] tt, logic [13:0] care, logic [13:0] e);
    ip <= p;
    itg <= t;
    ipcp <= pc;
    iip <= tos != 0;
    itos <= tos;
    ilk <= lk;
    ovr <= o;
    itail <= tt;
    iv <= 1;
    clq.push_back({care, e & care});
    @(posedge clk);
    iv <= 0;
    @(posedge clk);
  endtask
  // Sends one frame and predicts the edited bytes and their check sequence
  task automatic frame(logic [2:0] s, logic [2:0] d, logic t, int n, logic st, logic in,
                       logic [15:0] tci);
    logic [7:0] b[$], x[$];
    logic [31:0] c;
    for (int i = 0; i < n; i++) begin
      rng = xs(rng);
      b.push_back(t && i == 12 ? `TPID_HI : t && i == 13 ? `TPID_LO : rng[7:0]);
    end
    foreach (b[i]) begin
      if (in && !t && i == 12) x = {x, `TPID_HI, `TPID_LO, tci[15:8], tci[7:0]};
      if (!(st && t && i >= 12 && i < 16)) x.push_back(b[i]);
    end
    if (d == `HOST_PORT) x.push_back({6'h0, 2'(s - 3'h1)});
    c = `CRC_INIT;
    foreach (x[i]) c = crc8(c, x[i]);
    c = ~c;
    foreach (x[i]) txq.push_back({1'b0, x[i]});
    for (int i = 0; i < 4; i++) txq.push_back({i == 3, c[8*i+:8]});
    es <= s;
    edst <= d;
    etg <= t;
    slow <= rng[8];
    foreach (b[i]) begin
      ev <= 1;
      ed <= b[i];
      el <= i == n - 1;
      accept(0);
    end
    ev <= 0;
    el <= 0;
    for (int k = 0; k < 300 && txq.size() > 0; k++) @(posedge clk);
    @(posedge clk);
  endtask
  // Scoreboard and timeout, judged at the edge on values settled before it
  always @(posedge clk) begin
    if (rst_n && rd && wreq === 1'b0) chk("readdata", regq.pop_front(), rdata);
    if (cv === 1'b1) begin
      ce = clq.pop_front();
      chk("class", 32'(ce[13:0]), 32'({cm, lrn, cpcp, cds, cq, qv} & ce[27:14]));
    end
    if (fd === 1'b1) chk("flush", regq.pop_front(), 32'({fs, fp}));
    if (tv === 1'b1 && trdy === 1'b1) chk("tx", 32'(txq.pop_front()), 32'({tl, td}));
    if (++cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rdx(8'h00, `PC_RESET);
    rdx(8'h14, `GL_RESET);
    rdx(8'h18, 32'h0);
    bus(1, 8'hfc, 32'hffff_ffff);
    rdx(8'hfc, 32'h0);
    bus(1, 8'h00, 32'h0001_3384);
    bus(1, 8'h04, 32'h0001_4000);
    bus(1, 8'h08, 32'h0001_0000);
    bus(1, 8'h0c, 32'h0001_3002);
    bus(1, 8'h10, 32'h0);
    bus(1, 8'h18, 32'h0000_00e4);
    rdx(8'h04, 32'h0001_4000);
    regq.push_back(32'h12);
    bus(1, 8'h14, 32'h32);
    rdx(8'h14, 32'h2);
    cls(1, 1, 3'd6, 0, 5'h08, 0, 0, 14'h3fe0, {5'h08, 1'b1, 3'd3, 5'h0});
    cls(1, 1, 3'd2, 0, 5'h08, 0, 0, 14'h3fe0, {5'h08, 1'b1, 3'd2, 5'h0});
    for (int i = 1; i < 4; i++) cls(1, 0, 0, 8'(i << 2), 5'h08, 0, 0, 14'h0018, 14'(i << 3));
    cls(2, 0, 0, 0, 5'h18, 0, 0, 14'h3f00, 14'h0);
    cls(2, 0, 0, 0, 5'h18, 1, 0, 14'h3f00, {5'h10, 9'h0});
    cls(3, 0, 0, 0, 5'h19, 0, 0, 14'h3f00, {5'h10, 1'b1, 8'h0});
    cls(1, 0, 0, 0, 5'h14, 0, 0, 14'h3f00, {5'h10, 1'b1, 8'h0});
    cls(5, 0, 0, 0, 5'h00, 0, 8'h01, 14'h3e07, {5'h01, 6'h0, 3'h1});
    cls(5, 0, 0, 0, 5'h00, 0, 8'h31, 14'h3e07, {5'h01, 6'h0, 3'h7});
    cls(5, 0, 0, 0, 5'h00, 0, 8'h18, 14'h3e07, {5'h08, 6'h0, 3'h3});
    cls(5, 0, 0, 0, 5'h01, 0, 8'h00, 14'h3e00, 14'h0);
    cls(5, 0, 0, 0, 5'h00, 0, 8'h44, 14'h3e01, {5'h04, 9'h0});
    cls(5, 0, 0, 0, 5'h08, 0, 8'h8f, 14'h3e00, {5'h08, 9'h0});
    frame(1, 4, 1, 20, 1, 0, 16'h0);
    frame(1, 4, 0, 20, 1, 0, 16'h0);
    frame(3, 1, 0, 18, 0, 1, 16'h0001);
    frame(3, 1, 1, 18, 0, 1, 16'h0);
    frame(2, 5, 0, 16, 0, 0, 16'h0);
    frame(4, 5, 1, 16, 0, 0, 16'h0);
    rdx(8'h28, 32'h0000_068f);
    chk("leftover", 32'h0, regq.size() + clq.size() + txq.size());
    give_verdict();
  end
endmodule // tb_top
bind switch_port_state_tail_tag port_tag_checker i_chk (.*);
